// file: hw/ssu_top.sv
// serial slave unit: spi slave with byte dma channels and buffer semaphore
`timescale 1ns/1ps
`default_nettype none
`include "ssu_params.svh"
module ssu_top
   import ssu_pkg::*;
(
   input  wire logic                   core_clk,            // core clock, 100 MHz
   input  wire logic                   resetn,              // synchronous reset, active low
   input  wire logic                   enable,              // block enable
   input  wire logic                   cfg_cpol,            // clock polarity
   input  wire logic                   cfg_cpha,            // clock phase
   input  wire logic                   cfg_order,           // 0 msb first, 1 lsb first
   input  wire logic                   short_end_acquire,   // done-to-acquire shortcut
   input  wire logic [7:0]             tx_excess_flag_character,  // sent past tx limit
   input  wire logic [7:0]             default_character,   // sent in ignored transactions
   input  wire logic [`SSU_ADDR_W-1:0] rx_buffer_pointer,   // rx buffer base
   input  wire logic [`SSU_ADDR_W-1:0] tx_buffer_pointer,   // tx buffer base
   input  wire logic [`SSU_CNT_W-1:0]  rx_byte_limit,       // rx byte limit
   input  wire logic [`SSU_CNT_W-1:0]  tx_byte_limit,       // tx byte limit
   input  wire logic                   task_acquire,        // cpu acquire pulse
   input  wire logic                   task_release,        // cpu release pulse
   input  wire logic                   status_clear,        // clear status flags pulse
   input  wire logic                   chip_select_n,       // pin, active low
   input  wire logic                   sck,                 // pin, serial clock
   input  wire logic                   mosi,                // pin, data in
   output logic                        miso_o,              // serial data out
   output logic                        miso_oe_n,           // low while driving
   output logic                        sem_acquired_event,  // granted pulse
   output logic                        end_event,           // transaction done pulse
   output logic                        rx_buffer_full_event,// rx buffer full pulse
   output logic                        rx_overflow_flag,    // sticky receive overflow
   output logic                        tx_excess_flag,      // sticky over-read
   output logic [`SSU_CNT_W-1:0]       rx_byte_count,       // bytes written last time
   output logic [`SSU_CNT_W-1:0]       tx_byte_count,       // bytes read last time
   output logic                        sem_cpu_owned,       // semaphore held by cpu
   output logic                        dma_rd_req,          // tx read request
   output logic [`SSU_ADDR_W-1:0]      dma_rd_addr,         // tx read address
   input  wire logic                   dma_rd_ack,          // read data valid pulse
   input  wire logic [7:0]             dma_rd_data,         // read data
   output logic                        dma_wr_req,          // rx write request
   output logic [`SSU_ADDR_W-1:0]      dma_wr_addr,         // rx write address
   output logic [7:0]                  dma_wr_data,         // rx write data
   input  wire logic                   dma_wr_ack           // write taken pulse
);
   typedef struct packed {
      ssu_sem_type               sem;
      ssu_tr_type                tr;
      logic                      acq_pend;
      logic                      sck_prev;
      logic                      cs_prev;
      logic                      en_prev;
      logic [2:0]                bit_cnt;
      logic [7:0]                rx_sh;
      logic [7:0]                tx_sh;
      logic [7:0]                tx_next;
      logic                      tx_next_ok;
      logic [`SSU_CNT_W-1:0]     rx_n;
      logic [`SSU_CNT_W-1:0]     tx_n;
      logic [`SSU_CNT_W-1:0]     rx_cnt;
      logic [`SSU_CNT_W-1:0]     tx_cnt;
      logic                      rd_req;
      logic [`SSU_ADDR_W-1:0]    rd_addr;
      logic                      wr_req;
      logic [`SSU_ADDR_W-1:0]    wr_addr;
      logic [7:0]                wr_data;
      logic                      miso;
      logic                      oe_n;
      logic                      ev_acq;
      logic                      ev_end;
      logic                      ev_full;
      logic                      ovf;
      logic                      ovr;
      logic                      first_edge;
      logic                      cpu_own;
      logic [`SSU_CNT_W-1:0]     rx_out;
      logic [`SSU_CNT_W-1:0]     tx_out;
   } ssu_state_type;

   ssu_state_type st_q, st_d;
   logic [2:0]    pins_s;
   logic          cs_n_s, sck_s, mosi_s;

   // pins pass two flip-flops before any logic sees them
   ssu_sync #(.W(3)) u_sync (
      .core_clk (core_clk),
      .resetn   (resetn),
      .async_in ({chip_select_n, sck, mosi}),
      .rst_val  (3'h4),
      .sync_out (pins_s)
   );
   assign cs_n_s = pins_s[2];
   assign sck_s  = pins_s[1];
   assign mosi_s = pins_s[0];

   // bit picked for the line from a byte, given bit order
   function automatic logic pick_bit(input logic [7:0] b, input logic ord);
      pick_bit = (ord == `SSU_ORDER_LSB) ? b[0] : b[7];
   endfunction

   // byte shifted one place in transmit order
   function automatic logic [7:0] shift_tx(input logic [7:0] b, input logic ord);
      shift_tx = (ord == `SSU_ORDER_LSB) ? {1'b0, b[7:1]} : {b[6:0], 1'b0};
   endfunction

   logic cs_fall, cs_rise, sck_rise, sck_fall, lead, trail, samp, shft;
   logic [7:0] rx_byte;
   logic       en_rise;
   // the lead edge is the first edge away from idle polarity
   always_comb begin
      cs_fall  = st_q.cs_prev & ~cs_n_s;
      cs_rise  = ~st_q.cs_prev & cs_n_s;
      sck_rise = ~st_q.sck_prev & sck_s;
      sck_fall = st_q.sck_prev & ~sck_s;
      lead     = cfg_cpol ? sck_fall : sck_rise;
      trail    = cfg_cpol ? sck_rise : sck_fall;
      samp     = (cfg_cpha ? trail : lead) & ~cs_n_s;
      shft     = (cfg_cpha ? lead : trail) & ~cs_n_s;
      en_rise  = enable & ~st_q.en_prev;
      if (cfg_order == `SSU_ORDER_LSB) begin
         rx_byte = {mosi_s, st_q.rx_sh[7:1]};
      end else begin
         rx_byte = {st_q.rx_sh[6:0], mosi_s};
      end
   end

   // next state: semaphore, transaction, shifting and byte dma
   always_comb begin
      logic [7:0] nb;
      logic       load;
      logic       ovf_set;
      logic       ovr_set;
      nb      = 8'h00;
      load    = 1'b0;
      ovf_set = 1'b0;
      ovr_set = 1'b0;
      st_d    = st_q;
      st_d.sck_prev = sck_s;
      st_d.cs_prev  = cs_n_s;
      st_d.en_prev  = enable;
      st_d.ev_acq   = 1'b0;
      st_d.ev_end   = 1'b0;
      st_d.ev_full  = 1'b0;

      // dma handshakes retire on ack
      if (st_q.rd_req && dma_rd_ack) begin
         st_d.rd_req     = 1'b0;
         st_d.tx_next    = dma_rd_data;
         st_d.tx_next_ok = 1'b1;
      end
      if (st_q.wr_req && dma_wr_ack) begin
         st_d.wr_req = 1'b0;
      end

      // cpu tasks
      if (task_release && st_q.sem == SSU_SEM_CPU) begin
         st_d.sem = SSU_SEM_FREE;
      end // else no effect
      if (task_acquire) begin
         if (st_q.sem == SSU_SEM_CPU) begin
            st_d.ev_acq = 1'b1;
         end else if (st_q.sem == SSU_SEM_SLAVE) begin
            st_d.acq_pend = 1'b1;
         end else begin
            st_d.sem    = SSU_SEM_CPU;
            st_d.ev_acq = 1'b1;
         end
      end

      // chip select falls: slave tries for the semaphore; cpu wins a tie
      if (cs_fall && st_q.tr == SSU_TR_IDLE) begin
         st_d.bit_cnt = 3'h0;
         st_d.first_edge = 1'b1; // first bit is set up before any clock edge
         if (st_q.sem == SSU_SEM_FREE && !task_acquire) begin
            st_d.sem        = SSU_SEM_SLAVE;
            st_d.tr         = SSU_TR_GRANTED;
            st_d.rx_n       = '0;
            st_d.tx_n       = '0;
            st_d.rx_cnt     = '0;
            st_d.tx_cnt     = '0;
            st_d.rd_addr    = tx_buffer_pointer;
            st_d.wr_addr    = rx_buffer_pointer;
            st_d.tx_next_ok = 1'b0;
            if (tx_byte_limit != '0) begin
               st_d.rd_req = 1'b1;
               load        = 1'b0;
            end
            st_d.tx_sh = tx_excess_flag_character;
         end else begin
            st_d.tr    = SSU_TR_IGNORED;
            st_d.tx_sh = default_character;
         end
         st_d.oe_n = 1'b0;
         st_d.miso = pick_bit(st_d.tx_sh, cfg_order);
      end

      // first bit of a granted transaction once the tx byte arrives
      if (st_q.tr == SSU_TR_GRANTED && st_q.tx_n == '0 && st_q.bit_cnt == 3'h0 &&
          st_q.rd_req && dma_rd_ack) begin
         st_d.tx_sh      = dma_rd_data;
         st_d.miso       = pick_bit(dma_rd_data, cfg_order);
         st_d.tx_next_ok = 1'b0;
         st_d.tx_n       = `SSU_CNT_W'(1);
         st_d.tx_cnt     = `SSU_CNT_W'(1);
         st_d.rd_addr    = st_q.rd_addr + `SSU_ADDR_W'(1);
      end

      // sampling edge: collect bit, whole byte of a granted transaction goes to ram within the rx limit
      if (samp && st_q.tr != SSU_TR_IDLE) begin
         st_d.rx_sh   = rx_byte;
         st_d.bit_cnt = st_q.bit_cnt + 3'h1;
         st_d.first_edge = 1'b0;
         if (st_q.bit_cnt == `SSU_BIT_LAST) begin
            if (st_q.tr == SSU_TR_GRANTED) begin
               if (st_q.rx_n < rx_byte_limit) begin
                  st_d.wr_req  = 1'b1;
                  st_d.wr_data = rx_byte;
                  st_d.wr_addr = (st_q.rx_n == '0) ? st_q.wr_addr :
                                 st_q.wr_addr + `SSU_ADDR_W'(1);
                  st_d.rx_n    = st_q.rx_n + `SSU_CNT_W'(1);
                  st_d.rx_cnt  = st_q.rx_n + `SSU_CNT_W'(1);
                  if (st_q.rx_n + `SSU_CNT_W'(1) == rx_byte_limit) begin
                     st_d.ev_full = 1'b1;
                  end
               end else begin
                  st_d.ovf = 1'b1;
                  ovf_set  = 1'b1;
               end
            end
         end
      end

      // shifting edge: next bit, or next byte at a byte boundary
      if (shft && st_q.tr != SSU_TR_IDLE) begin
         if (st_q.first_edge) begin
            st_d.first_edge = 1'b0; // phase 1 lead edge keeps the preloaded bit
         end else if (st_q.bit_cnt == 3'h0) begin
            load = 1'b1;
         end else begin
            st_d.tx_sh = shift_tx(st_q.tx_sh, cfg_order);
            st_d.miso  = pick_bit(shift_tx(st_q.tx_sh, cfg_order), cfg_order);
         end
      end
      if (load && st_q.tr == SSU_TR_IGNORED) begin
         nb = default_character;
      end else if (load && st_q.tx_n < tx_byte_limit && st_q.tx_next_ok) begin
         nb              = st_q.tx_next;
         st_d.tx_next_ok = 1'b0;
         st_d.tx_n       = st_q.tx_n + `SSU_CNT_W'(1);
         st_d.tx_cnt     = st_q.tx_n + `SSU_CNT_W'(1);
         st_d.rd_addr    = st_q.rd_addr + `SSU_ADDR_W'(1);
      end else if (load) begin
         nb = tx_excess_flag_character;
         if (st_q.tx_n >= tx_byte_limit) begin
            st_d.ovr = 1'b1;
            ovr_set  = 1'b1;
         end
      end
      if (load) begin
         st_d.tx_sh = nb;
         st_d.miso  = pick_bit(nb, cfg_order);
      end

      // prefetch the following tx byte while the current one shifts
      if (st_q.tr == SSU_TR_GRANTED && !st_q.rd_req && !st_q.tx_next_ok &&
          st_q.tx_n != '0 && st_q.tx_n < tx_byte_limit && !cs_n_s) begin
         st_d.rd_req = 1'b1;
      end

      // chip select rises: end, release, hand over to pending cpu
      if (cs_rise && st_q.tr != SSU_TR_IDLE) begin
         st_d.oe_n = 1'b1;
         st_d.tr   = SSU_TR_IDLE;
         st_d.rd_req = 1'b0;
         if (st_q.tr == SSU_TR_GRANTED) begin
            st_d.ev_end = 1'b1;
            st_d.rx_out = st_q.rx_cnt;
            st_d.tx_out = st_q.tx_cnt;
            if (st_q.acq_pend || short_end_acquire) begin
               st_d.sem      = SSU_SEM_CPU;
               st_d.ev_acq   = 1'b1;
               st_d.acq_pend = 1'b0;
            end else begin
               st_d.sem = SSU_SEM_FREE;
            end
         end
      end

      if (status_clear) begin
         st_d.ovf = ovf_set; // set in the same cycle wins over clear
         st_d.ovr = ovr_set;
      end

      // enable start: cpu owns semaphore, no event
      if (en_rise) begin
         st_d.sem    = SSU_SEM_CPU;
         st_d.ev_acq = 1'b0;
      end
      if (!enable) begin
         st_d.sem  = SSU_SEM_FREE;
         st_d.tr   = SSU_TR_IDLE;
         st_d.oe_n = 1'b1;
         st_d.rd_req = 1'b0;
         st_d.wr_req = 1'b0;
         st_d.ev_acq = 1'b0;
         st_d.ev_end = 1'b0;
         st_d.ev_full = 1'b0;
         st_d.acq_pend = 1'b0;
      end
      if (!resetn) begin
         st_d      = '0;
         st_d.sem  = SSU_SEM_FREE;
         st_d.tr   = SSU_TR_IDLE;
         st_d.oe_n = 1'b1;
         st_d.cs_prev = 1'b1;
         st_d.en_prev = 1'b0;
      end
      // owner flag kept in its own flip-flop so the port is registered
      st_d.cpu_own = (st_d.sem == SSU_SEM_CPU);
   end

   always_ff @(posedge core_clk) begin
      st_q <= st_d;
   end

   // outputs straight from flip-flops
   assign miso_o               = st_q.miso;
   assign miso_oe_n            = st_q.oe_n;
   assign sem_acquired_event   = st_q.ev_acq;
   assign end_event            = st_q.ev_end;
   assign rx_buffer_full_event = st_q.ev_full;
   assign rx_overflow_flag     = st_q.ovf;
   assign tx_excess_flag       = st_q.ovr;
   assign rx_byte_count        = st_q.rx_out;
   assign tx_byte_count        = st_q.tx_out;
   assign dma_rd_req           = st_q.rd_req;
   assign dma_rd_addr          = st_q.rd_addr;
   assign dma_wr_req           = st_q.wr_req;
   assign dma_wr_addr          = st_q.wr_addr;
   assign dma_wr_data          = st_q.wr_data;
   // cpu ownership flag comes from its own flip-flop
   assign sem_cpu_owned        = st_q.cpu_own;
endmodule
`default_nettype wire

// file: hw/ssu_params.svh
// constants for the serial slave unit with buffer dma and semaphore
`ifndef SSU_PARAMS_SVH
`define SSU_PARAMS_SVH
`define SSU_ADDR_W 32
`define SSU_CNT_W 13
`define SSU_ORDER_MSB 1'b0
`define SSU_ORDER_LSB 1'b1
`define SSU_BIT_LAST 3'h7
`endif

// file: hw/ssu_pkg.sv
// types for the serial slave unit
`include "ssu_params.svh"
package ssu_pkg;
   typedef enum logic [1:0] {SSU_SEM_FREE, SSU_SEM_CPU, SSU_SEM_SLAVE} ssu_sem_type;
   typedef enum logic [1:0] {SSU_TR_IDLE, SSU_TR_GRANTED, SSU_TR_IGNORED} ssu_tr_type;
endpackage

// file: hw/ssu_sync.sv
// two flip-flop synchroniser for the serial pins
`timescale 1ns/1ps
`default_nettype none
module ssu_sync
   import ssu_pkg::*;
#(
   parameter int W = 3
) (
   input  wire logic         core_clk, // core clock
   input  wire logic         resetn,   // synchronous reset, active low
   input  wire logic [W-1:0] async_in, // pins from outside the domain
   input  wire logic [W-1:0] rst_val,  // idle level after reset
   output logic      [W-1:0] sync_out  // synchronised copy
);
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
   } ssu_sync_state_type;
   ssu_sync_state_type st_q, st_d;

   // first stage only feeds the second
   always_comb begin
      st_d    = st_q;
      st_d.s1 = async_in;
      st_d.s2 = st_q.s1;
      if (!resetn) begin
         st_d.s1 = rst_val;
         st_d.s2 = rst_val;
      end
   end

   always_ff @(posedge core_clk) begin
      st_q <= st_d;
   end

   assign sync_out = st_q.s2;
endmodule
`default_nettype wire

// file: sim/ssu_sva.sv
// assertions on the ports of the serial slave unit
`timescale 1ns/1ps
`default_nettype none
`include "ssu_params.svh"
module ssu_sva
   import ssu_pkg::*;
(
   input wire logic                   core_clk,           // clock
   input wire logic                   resetn,             // reset
   input wire logic                   enable,             // enable
   input wire logic                   short_end_acquire,  // shortcut
   input wire logic                   task_acquire,       // acquire
   input wire logic                   task_release,       // release
   input wire logic                   status_clear,       // flag clear
   input wire logic                   chip_select_n,      // select pin
   input wire logic                   miso_oe_n,          // drive enable
   input wire logic                   sem_acquired_event, // granted
   input wire logic                   end_event,          // done
   input wire logic                   rx_overflow_flag,   // overflow
   input wire logic                   tx_excess_flag,     // over-read
   input wire logic [`SSU_CNT_W-1:0]  rx_byte_count,      // rx count
   input wire logic                   sem_cpu_owned,      // cpu owner
   input wire logic                   dma_rd_req,         // read req
   input wire logic [`SSU_ADDR_W-1:0] dma_rd_addr,        // read addr
   input wire logic                   dma_rd_ack,         // read ack
   input wire logic                   dma_wr_req,         // write req
   input wire logic [`SSU_ADDR_W-1:0] dma_wr_addr,        // write addr
   input wire logic [7:0]             dma_wr_data,        // write data
   input wire logic                   dma_wr_ack          // write ack
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!resetn);
   // the two sync stages and the oe_n register cost three cycles, so idle is judged over four
   sequence s_cs_idle;
      chip_select_n [*4];
   endsequence
   sequence s_rd_wait;
      dma_rd_req && !dma_rd_ack;
   endsequence
   sequence s_wr_wait;
      dma_wr_req && !dma_wr_ack;
   endsequence
   AST_OE_IDLE: assert property (s_cs_idle |-> miso_oe_n)
      else $error("miso driven while deselected");
   AST_EN_NO_EVT: assert property ($rose(enable) && !task_acquire |=>
      !sem_acquired_event ##[0:1] sem_cpu_owned) else $error("bad handover on enable");
   AST_ACQ_NOW: assert property (task_acquire && sem_cpu_owned |=> sem_acquired_event)
      else $error("no grant for cpu owner");
   AST_REL_NOP: assert property (task_release && !sem_cpu_owned && !task_acquire &&
      !short_end_acquire && chip_select_n |=> !sem_cpu_owned) else $error("release changed owner");
   AST_END_CS: assert property (end_event |-> chip_select_n && $past(chip_select_n, 2))
      else $error("done without select rise");
   AST_CNT_END: assert property ($changed(rx_byte_count) |-> end_event || $past(end_event))
      else $error("count moved outside done");
   AST_OVF_STICKY: assert property ($fell(rx_overflow_flag) |-> $past(status_clear))
      else $error("overflow flag lost");
   AST_EXC_STICKY: assert property ($fell(tx_excess_flag) |-> $past(status_clear))
      else $error("over-read flag lost");
   AST_RD_HOLD: assert property (s_rd_wait |=> dma_rd_req && $stable(dma_rd_addr))
      else $error("read request dropped");
   AST_WR_HOLD: assert property (s_wr_wait |=> dma_wr_req && $stable(dma_wr_addr) &&
      $stable(dma_wr_data)) else $error("write request dropped");
   AST_CPU_NO_DMA: assert property (sem_cpu_owned |-> !dma_wr_req && !dma_rd_req)
      else $error("ram touched while cpu owns");
endmodule
`default_nettype wire

// file: sim/ssu_master.sv
// spi master model driving select, clock and data
`timescale 1ns/1ps
`default_nettype none
module ssu_master (
   input  wire logic cpol,          // clock polarity
   input  wire logic cpha,          // clock phase
   input  wire logic order,         // 0 msb first
   input  wire logic miso,          // data from slave
   output logic      chip_select_n, // select, active low
   output logic      sck,           // serial clock
   output logic      mosi           // data to slave
);
   logic [7:0] mo [0:7];
   logic [7:0] mi [0:7];
   int         i;
   int         b;
   initial begin
      chip_select_n = 1'b1;
      sck = 1'b0;
      mosi = 1'b0;
   end
   // 80 ns bit, 55 ns from shift to sample so the synchronised slave output settles
   task frame(input int nbits);
      sck = cpol;
      #100 chip_select_n = 1'b0;
      #200;
      for (i = 0; i < nbits; i++) begin
         b = order ? i % 8 : 7 - i % 8;
         if (cpha) sck = ~cpol;
         else if (i > 0) sck = cpol;
         mosi = mo[i/8][b];
         #55 sck = cpha ? cpol : ~cpol;
         mi[i/8][b] = miso;
         #25;
      end
      if (!cpha) sck = cpol;
      #100 chip_select_n = 1'b1;
      mosi = ~mosi; // released line must not keep the last bit
   endtask
endmodule
`default_nettype wire

// file: sim/ssu_top_tb.sv
// self-checking bench for the serial slave unit
`timescale 1ns/1ps
`default_nettype none
`include "ssu_params.svh"
module ssu_top_tb;
   import ssu_pkg::*;
   logic                   core_clk, resetn, enable, cfg_cpol, cfg_cpha, cfg_order;
   logic                   short_end_acquire, task_acquire, task_release, status_clear;
   logic [7:0]             tx_excess_flag_character, default_character, dma_rd_data, dma_wr_data;
   logic [`SSU_ADDR_W-1:0] rx_buffer_pointer, tx_buffer_pointer, dma_rd_addr, dma_wr_addr;
   logic [`SSU_CNT_W-1:0]  rx_byte_limit, tx_byte_limit, rx_byte_count, tx_byte_count;
   logic                   miso_o, miso_oe_n, sem_acquired_event, end_event;
   logic                   rx_buffer_full_event, rx_overflow_flag, tx_excess_flag;
   logic                   sem_cpu_owned, dma_rd_req, dma_rd_ack, dma_wr_req, dma_wr_ack;
   wire                    chip_select_n, sck, mosi;
   wire                    miso = miso_oe_n ? 1'bz : miso_o;
   logic [7:0]             ram [0:255];
   logic [39:0]            exp_q [$];
   logic [15:0]            seed;
   int                     errors, checks_done, n_end, n_full, n_acq, e0, f0, a0, i, k;
   ssu_top dut (.core_clk, .resetn, .enable, .cfg_cpol, .cfg_cpha, .cfg_order,
      .short_end_acquire, .tx_excess_flag_character, .default_character, .rx_buffer_pointer,
      .tx_buffer_pointer, .rx_byte_limit, .tx_byte_limit, .task_acquire, .task_release,
      .status_clear, .chip_select_n, .sck, .mosi, .miso_o, .miso_oe_n, .sem_acquired_event,
      .end_event, .rx_buffer_full_event, .rx_overflow_flag, .tx_excess_flag, .rx_byte_count,
      .tx_byte_count, .sem_cpu_owned, .dma_rd_req, .dma_rd_addr, .dma_rd_ack, .dma_rd_data,
      .dma_wr_req, .dma_wr_addr, .dma_wr_data, .dma_wr_ack);
   ssu_master m (.cpol(cfg_cpol), .cpha(cfg_cpha), .order(cfg_order), .miso, .chip_select_n,
      .sck, .mosi);
   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   task chk(input logic [39:0] seen, input logic [39:0] exp);
      checks_done++;
      if (seen !== exp) begin
         errors++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task final_report;
      if (errors == 0 && checks_done > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   // cpu task pulses, then two cycles for the answering event to land
   task cpu(input logic a, input logic r, input logic c);
      @(negedge core_clk);
      {task_acquire, task_release, status_clear} = {a, r, c};
      @(negedge core_clk);
      {task_acquire, task_release, status_clear} = 3'h0;
      repeat (2) @(negedge core_clk);
   endtask
   // random master bytes; writes are noted only for the bytes within the rx limit
   task load(input int n, input logic note);
      for (k = 0; k < n; k++) begin
         seed = lfsr(seed);
         m.mo[k] = seed[7:0];
         if (note && k < rx_byte_limit) exp_q.push_back({rx_buffer_pointer + k, seed[7:0]});
      end
   endtask
   task run(input int nbits);
      m.frame(nbits);
      repeat (10) @(posedge core_clk);
      #1;
   endtask
   // granted frame with a cpu acquire in mid-frame; the grant waits for the end
   task acq_run;
      load(2, 1'b1);
      a0 = n_acq;
      fork
         run(16);
         begin
            #600;
            cpu(1'b1, 1'b0, 1'b0);
            chk(sem_cpu_owned, 1'b0);
         end
      join
      chk(sem_cpu_owned, 1'b1);
      chk(n_acq - a0, 1);
   endtask
   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end
   // ram behind both channels, each request answered one cycle later
   always @(negedge core_clk) begin
      dma_rd_ack <= dma_rd_req && !dma_rd_ack;
      dma_rd_data <= ram[dma_rd_addr[7:0]];
      dma_wr_ack <= dma_wr_req && !dma_wr_ack;
      if (dma_wr_req && !dma_wr_ack) ram[dma_wr_addr[7:0]] <= dma_wr_data;
   end
   // event counters and scoreboard: each ram write takes the oldest note
   always @(posedge core_clk) begin
      if (end_event === 1'b1) n_end++;
      if (rx_buffer_full_event === 1'b1) n_full++;
      if (sem_acquired_event === 1'b1) n_acq++;
      if (dma_wr_req === 1'b1 && dma_wr_ack === 1'b1) begin
         if (exp_q.size() == 0) chk(40'h1, 40'h0);
         else chk({dma_wr_addr, dma_wr_data}, exp_q.pop_front());
      end
   end
   initial begin
      {enable, cfg_cpol, cfg_cpha, cfg_order, short_end_acquire, resetn} = 6'h00;
      {task_acquire, task_release, status_clear} = 3'h0;
      tx_excess_flag_character = 8'ha5;
      default_character = 8'h3c;
      rx_buffer_pointer = 32'h0000_0080;
      tx_buffer_pointer = 32'h0000_0010;
      rx_byte_limit = 13'h0002;
      tx_byte_limit = 13'h0003;
      seed = 16'he290;
      for (i = 0; i < 256; i++) begin
         seed = lfsr(seed);
         ram[i] = seed[7:0];
      end
      repeat (5) @(negedge core_clk);
      resetn = 1'b1;
      @(negedge core_clk);
      enable = 1'b1;
      repeat (3) @(negedge core_clk);
      chk(sem_cpu_owned, 1'b1);
      chk(n_acq, 0);
      cpu(1'b1, 1'b0, 1'b0);
      chk(n_acq, 1);
      cpu(1'b0, 1'b1, 1'b0);
      chk(sem_cpu_owned, 1'b0);
      cpu(1'b0, 1'b1, 1'b0);
      chk(sem_cpu_owned, 1'b0);
      // all four modes back to back, both limits overrun, a trailing half byte
      for (i = 0; i < 4; i++) begin
         @(negedge core_clk);
         cfg_cpol = i[1];
         cfg_cpha = i[0];
         cfg_order = i[1] ^ i[0];
         cpu(1'b0, 1'b0, 1'b1);
         e0 = n_end;
         f0 = n_full;
         load(5, 1'b1);
         run(36);
         for (k = 0; k < 3; k++) chk(m.mi[k], ram[tx_buffer_pointer[7:0] + k]);
         chk(m.mi[3], tx_excess_flag_character);
         chk(rx_byte_count, 13'h0002);
         chk(tx_byte_count, 13'h0003);
         chk({rx_overflow_flag, tx_excess_flag}, 2'h3);
         chk(n_end - e0, 1);
         chk(n_full - f0, 1);
         chk(exp_q.size(), 0);
      end
      // cpu holds the semaphore at select; a release mid-frame must not revive it
      cpu(1'b1, 1'b0, 1'b0);
      e0 = n_end;
      load(2, 1'b0);
      fork
         run(16);
         begin
            #600;
            cpu(1'b0, 1'b1, 1'b0);
         end
      join
      chk(m.mi[0], default_character);
      chk(m.mi[1], default_character);
      chk(n_end - e0, 0);
      @(negedge core_clk);
      short_end_acquire = 1'b1;
      acq_run;
      cpu(1'b0, 1'b1, 1'b0);
      short_end_acquire = 1'b0;
      acq_run;
      final_report;
   end
   initial begin
      #200000;
      errors++;
      final_report;
   end
endmodule
bind ssu_top ssu_sva u_sva (.core_clk, .resetn, .enable, .short_end_acquire, .task_acquire,
   .task_release, .status_clear, .chip_select_n, .miso_oe_n, .sem_acquired_event, .end_event,
   .rx_overflow_flag, .tx_excess_flag, .rx_byte_count, .sem_cpu_owned, .dma_rd_req,
   .dma_rd_addr, .dma_rd_ack, .dma_wr_req, .dma_wr_addr, .dma_wr_data, .dma_wr_ack);
`default_nettype wire
